// ==== core/udsc_device.sv ====
// Device end: USB device-state, suspend, resume and remote-wake control with
// its register file. Assumes bus conditions arrive already decoded as levels
// and pulses synchronous to clk.
//
// Summary of operation
// RULE1: Single bank cancel: clear ready, then reset endpoint
// RULE2: Dual bank cancel: toggle ready with polls, reset
// RULE3: State changes only on bus events or requests
// RULE4: Idle bus sets suspend flag; clear enters suspend
// RULE5: Pull-up follows connect bit; connecting means powered
// RULE6: Registers touched only while port clock enabled
// RULE7: End of bus reset flags unmaskably, enters default
// RULE8: Bus reset restores mask and endpoint registers
// RULE9: Default state: enable endpoint 0, mask, transceiver
// RULE10: After status stage, set address then enable
// RULE11: Set configuration enables configured endpoints
// RULE12: Suspended resume detection sets wakeup flag
// RULE13: Clock before clearing wakeup; keep pull-up
// RULE14: Gate bus clock last when suspending
// RULE15: Wake after 5 ms suspend; K 1..15 ms
// RULE16: Enable clocks, wake enable, write resume 0 then 1
// RULE17: Resume bit rise drives and releases K
// RULE18: No host: gate clocks, disable transceiver
`timescale 1ns/1ps
`include "udsc_cfg.svh"
module udsc_device #(
	parameter int IDLE_CYC = `UDSC_SUSP_IDLE_MS * (`UDSC_CLK_HZ / 1000),
	parameter int WAKE_CYC = `UDSC_WAKE_WAIT_MS * (`UDSC_CLK_HZ / 1000),
	parameter int KDRV_CYC = `UDSC_KDRIVE_MS * (`UDSC_CLK_HZ / 1000)
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register side
	udsc_reg_if.dev rif,
	// Bus conditions
	input wire logic busIdle,
	input wire logic busResetSe0,
	input wire logic [1:0] inAck,
	// Bus drive and status
	output logic pullupOn,
	output logic kStateDrive,
	output logic transceiverOn,
	output logic suspended,
	output udsc_pkg::udsc_dstate_e devState
);
	import udsc_pkg::*;

	typedef struct packed
	{
		udsc_dstate_e dstate;
		logic susp;
		logic suspPend;
		logic [4:0] glb;
		logic [7:0] faddr;
		logic [13:0] imr;
		logic [13:0] isr;
		logic [1:0] tpr;
		logic [1:0] txc;
		logic [1:0] epEn;
		logic [1:0][2:0] kind;
		logic [1:0] rstEp;
		logic transceiver_disable_bit;
		logic pullup_connect_bit;
		logic se0Q;
		logic wakePend;
		logic kOn;
		logic [31:0] rdata;
	} udsc_dev_s;

	udsc_dev_s s_ff;
	udsc_dev_s nxt_s;
	logic idleExp;
	logic wakeExp;
	logic kExp;
	logic wrOk;
	logic rdOk;
	logic end_of_bus_reset_flag;
	logic esrRise;
	logic [13:0] isrView;

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	// Suspend detection only counts while attached to a host and awake
	udsc_timer #(.LIMIT(IDLE_CYC)) u_idle
	(
		.clk(clk),
		.rst(rst),
		.run(busIdle && s_ff.pullup_connect_bit && !s_ff.susp && !s_ff.suspPend),
		.expired(idleExp)
	);
	udsc_timer #(.LIMIT(WAKE_CYC)) u_wake
	(
		.clk(clk),
		.rst(rst),
		.run(s_ff.susp),
		.expired(wakeExp)
	);
	// Timer counts from zero, so one less keeps K exactly KDRV_CYC cycles
	udsc_timer #(.LIMIT(KDRV_CYC - 1)) u_kdrv
	(
		.clk(clk),
		.rst(rst),
		.run(s_ff.kOn),
		.expired(kExp)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// A gated bus clock leaves the port deaf to software
	assign wrOk = rif.regWr && rif.busClkOn; // RULE6
	assign rdOk = rif.regRd && rif.busClkOn; // RULE6
	assign end_of_bus_reset_flag = s_ff.se0Q && !busResetSe0 && s_ff.pullup_connect_bit;
	assign esrRise = wrOk && (rif.regAddr == `UDSC_OFS_GLB) && !s_ff.glb[`UDSC_GLB_ESR]
		&& rif.regWdata[`UDSC_GLB_ESR];

	always_comb
	begin
		isrView = s_ff.isr;
		isrView[`UDSC_ISR_EP0] = s_ff.txc[0];
		isrView[`UDSC_ISR_EP1] = s_ff.txc[1];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.se0Q = busResetSe0;

		// Register writes
		if (wrOk)
		begin
			case (rif.regAddr)
				`UDSC_OFS_GLB:
				begin
					nxt_s.glb[`UDSC_GLB_ESR] = rif.regWdata[`UDSC_GLB_ESR];
					nxt_s.glb[`UDSC_GLB_REMOTE_WAKE_ENABLE] = rif.regWdata[`UDSC_GLB_REMOTE_WAKE_ENABLE];
					nxt_s.glb[`UDSC_GLB_CONFG] = rif.regWdata[`UDSC_GLB_CONFG];
					// Only a bus reset takes the address state away
					if (rif.regWdata[`UDSC_GLB_ADDRESS_STATE_FLAG])
						nxt_s.glb[`UDSC_GLB_ADDRESS_STATE_FLAG] = 1'b1;
				end
				`UDSC_OFS_FADDR: nxt_s.faddr = rif.regWdata[7:0];
				`UDSC_OFS_IER: nxt_s.imr = s_ff.imr | rif.regWdata[13:0];
				`UDSC_OFS_IDR: nxt_s.imr = s_ff.imr & ~rif.regWdata[13:0];
				`UDSC_OFS_ICR: nxt_s.isr = s_ff.isr & ~rif.regWdata[13:0];
				`UDSC_OFS_RSTEP:
				begin
					nxt_s.rstEp = rif.regWdata[1:0];
					nxt_s.tpr = s_ff.tpr & ~rif.regWdata[1:0]; // RULE1
				end
				`UDSC_OFS_TXVC:
				begin
					nxt_s.transceiver_disable_bit = rif.regWdata[`UDSC_TXVC_TRANSCEIVER_DISABLE_BIT];
					nxt_s.pullup_connect_bit = rif.regWdata[`UDSC_TXVC_PULLUP_CONNECT_BIT];
				end
				default:
				begin
					for (int e = 0; e < 2; e++)
					begin
						if (rif.regAddr == (`UDSC_OFS_CSR + 8'(4 * e)))
						begin
							nxt_s.tpr[e] = rif.regWdata[`UDSC_CSR_TX_PACKET_READY];
							nxt_s.txc[e] = s_ff.txc[e] & rif.regWdata[`UDSC_CSR_TX_COMPLETE_FLAG];
							nxt_s.epEn[e] = rif.regWdata[`UDSC_CSR_EPEN];
							nxt_s.kind[e] = rif.regWdata[`UDSC_CSR_KIND_LO +: 3];
						end
					end
				end
			endcase
		end

		// Packet taken by the host: ready drops, complete sets over a software clear
		for (int e = 0; e < 2; e++)
		begin
			if (inAck[e] && s_ff.tpr[e] && s_ff.epEn[e])
			begin
				nxt_s.tpr[e] = 1'b0;
				nxt_s.txc[e] = 1'b1;
			end
		end

		// Suspend: flag first, enter once software has cleared it
		if (idleExp)
		begin
			nxt_s.isr[`UDSC_ISR_SUSPEND_DETECTED_FLAG] = 1'b1; // RULE4
			nxt_s.suspPend = 1'b1;
		end
		else if (s_ff.suspPend && !s_ff.isr[`UDSC_ISR_SUSPEND_DETECTED_FLAG])
		begin
			nxt_s.suspPend = 1'b0;
			nxt_s.susp = 1'b1; // RULE4
		end
		if (!busIdle)
			nxt_s.suspPend = 1'b0;

		// Host resume; seen with clocks gated, so no clock enable is checked
		if (s_ff.susp && !busIdle && !s_ff.kOn)
		begin
			nxt_s.susp = 1'b0;
			nxt_s.wakePend = 1'b0;
			nxt_s.isr[`UDSC_ISR_WAKEUP] = 1'b1; // RULE12
			nxt_s.isr[`UDSC_ISR_RXRSM] = 1'b1; // RULE12
		end

		// Remote wake: held until 5 ms of suspend, then a timed K
		if (esrRise && s_ff.glb[`UDSC_GLB_REMOTE_WAKE_ENABLE] && s_ff.susp)
			nxt_s.wakePend = 1'b1; // RULE17
		if (s_ff.wakePend && wakeExp && !s_ff.kOn)
		begin
			nxt_s.wakePend = 1'b0;
			nxt_s.kOn = 1'b1; // RULE15
		end
		if (kExp)
		begin
			nxt_s.kOn = 1'b0; // RULE17
			nxt_s.susp = 1'b0;
		end

		// Device state; only bus events and software writes move it
		case (s_ff.dstate)
			ST_ATTACHED:
				if (s_ff.pullup_connect_bit)
					nxt_s.dstate = ST_POWERED; // RULE5
			ST_POWERED, ST_DEFAULT:
				if (nxt_s.glb[`UDSC_GLB_ADDRESS_STATE_FLAG])
					nxt_s.dstate = ST_ADDRESS; // RULE3
			ST_ADDRESS:
				if (nxt_s.glb[`UDSC_GLB_CONFG])
					nxt_s.dstate = ST_CONFIG; // RULE3
			ST_CONFIG:
				if (!nxt_s.glb[`UDSC_GLB_CONFG])
					nxt_s.dstate = ST_ADDRESS; // RULE3
			default: nxt_s.dstate = ST_ATTACHED;
		endcase

		// End of bus reset wins over software writes to address, configuration, mask and endpoint controls this cycle
		if (end_of_bus_reset_flag)
		begin
			nxt_s.dstate = ST_DEFAULT; // RULE7
			nxt_s.isr[`UDSC_ISR_END_OF_BUS_RESET_FLAG] = 1'b1; // RULE7
			nxt_s.susp = 1'b0;
			nxt_s.suspPend = 1'b0;
			nxt_s.glb[`UDSC_GLB_ADDRESS_STATE_FLAG] = 1'b0;
			nxt_s.glb[`UDSC_GLB_CONFG] = 1'b0;
			nxt_s.faddr = `UDSC_FADDR_RST;
			nxt_s.imr = `UDSC_IMR_RST; // RULE8
			nxt_s.tpr = 2'h0; // RULE8
			nxt_s.txc = 2'h0; // RULE8
			nxt_s.epEn = 2'h0; // RULE8
			nxt_s.kind = '0; // RULE8
		end
		if (!s_ff.pullup_connect_bit)
			nxt_s.dstate = ST_ATTACHED; // RULE5

		// Read data
		if (rdOk)
		begin
			case (rif.regAddr)
				`UDSC_OFS_GLB: nxt_s.rdata = {27'h0, s_ff.glb};
				`UDSC_OFS_FADDR: nxt_s.rdata = {24'h0, s_ff.faddr};
				`UDSC_OFS_IMR: nxt_s.rdata = {18'h0, s_ff.imr};
				`UDSC_OFS_ISR: nxt_s.rdata = {18'h0, isrView};
				`UDSC_OFS_RSTEP: nxt_s.rdata = {30'h0, s_ff.rstEp};
				`UDSC_OFS_TXVC: nxt_s.rdata = {22'h0, s_ff.pullup_connect_bit, s_ff.transceiver_disable_bit, 8'h0};
				default:
				begin
					nxt_s.rdata = 32'h0;
					for (int e = 0; e < 2; e++)
					begin
						if (rif.regAddr == (`UDSC_OFS_CSR + 8'(4 * e)))
							nxt_s.rdata = {16'h0, s_ff.epEn[e], 4'h0, s_ff.kind[e], 3'h0,
								s_ff.tpr[e], 3'h0, s_ff.txc[e]};
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_ff <= '0;
			s_ff.dstate <= ST_ATTACHED;
			s_ff.glb <= `UDSC_GLB_RST;
			s_ff.faddr <= `UDSC_FADDR_RST;
			s_ff.imr <= `UDSC_IMR_RST;
			s_ff.transceiver_disable_bit <= `UDSC_TXVC_RST;
		end
		else
			s_ff <= nxt_s;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// End of bus reset cannot be masked
	assign rif.irq = |(isrView & (s_ff.imr | 14'h1000)); // RULE7
	assign rif.regRdata = s_ff.rdata;
	assign pullupOn = s_ff.pullup_connect_bit; // RULE5
	assign kStateDrive = s_ff.kOn;
	assign transceiverOn = !s_ff.transceiver_disable_bit;
	assign suspended = s_ff.susp;
	assign devState = s_ff.dstate;
endmodule : udsc_device

// ==== inc/udsc_cfg.svh ====
// Constants of the USB device-state control block: offsets, field positions,
// reset values and timing. Included by the device, timer and firmware files.
`ifndef UDSC_CFG_SVH
`define UDSC_CFG_SVH

// ----------------------------------------
// Clock and times
// ----------------------------------------
`define UDSC_CLK_HZ 20000000
`define UDSC_SUSP_IDLE_MS 3
`define UDSC_WAKE_WAIT_MS 5
`define UDSC_KDRIVE_MS 2

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define UDSC_OFS_GLB 8'h04
`define UDSC_OFS_FADDR 8'h08
`define UDSC_OFS_IER 8'h10
`define UDSC_OFS_IDR 8'h14
`define UDSC_OFS_IMR 8'h18
`define UDSC_OFS_ISR 8'h1c
`define UDSC_OFS_ICR 8'h20
`define UDSC_OFS_RSTEP 8'h28
`define UDSC_OFS_CSR 8'h30
`define UDSC_OFS_TXVC 8'h74

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UDSC_GLB_ADDRESS_STATE_FLAG 0
`define UDSC_GLB_CONFG 1
`define UDSC_GLB_ESR 2
`define UDSC_GLB_REMOTE_WAKE_ENABLE 4
`define UDSC_FADDR_FEN 7
`define UDSC_ISR_EP0 0
`define UDSC_ISR_EP1 1
`define UDSC_ISR_SUSPEND_DETECTED_FLAG 8
`define UDSC_ISR_RXRSM 9
`define UDSC_ISR_END_OF_BUS_RESET_FLAG 12
`define UDSC_ISR_WAKEUP 13
`define UDSC_CSR_TX_COMPLETE_FLAG 0
`define UDSC_CSR_TX_PACKET_READY 4
`define UDSC_CSR_KIND_LO 8
`define UDSC_CSR_EPEN 15
`define UDSC_TXVC_TRANSCEIVER_DISABLE_BIT 8
`define UDSC_TXVC_PULLUP_CONNECT_BIT 9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UDSC_GLB_RST 5'h10
`define UDSC_FADDR_RST 8'h80
`define UDSC_IMR_RST 14'h1200
`define UDSC_TXVC_RST 1'h1

`endif

// ==== inc/udsc_pkg.sv ====
// Types shared by both ends of the USB device-state control block.
// Numbers live in udsc_cfg.svh.
package udsc_pkg;

	typedef enum logic [4:0]
	{
		ST_ATTACHED = 5'h01,
		ST_POWERED = 5'h02,
		ST_DEFAULT = 5'h04,
		ST_ADDRESS = 5'h08,
		ST_CONFIG = 5'h10
	} udsc_dstate_e;

	typedef enum logic [4:0]
	{
		SQ_IDLE = 5'h01,
		SQ_ISSUE = 5'h02,
		SQ_READ = 5'h04,
		SQ_EVAL = 5'h08,
		SQ_WRITE = 5'h10
	} udsc_seq_e;

	typedef enum logic [3:0]
	{
		CMD_CANCEL1 = 4'h0,
		CMD_CANCEL2 = 4'h1,
		CMD_DEFAULT = 4'h2,
		CMD_SETADDR = 4'h3,
		CMD_CONFIG = 4'h4,
		CMD_SUSPEND = 4'h5,
		CMD_RESUME = 4'h6,
		CMD_RWAKE = 4'h7,
		CMD_CONNECT = 4'h8,
		CMD_PWRDOWN = 4'h9
	} udsc_cmd_e;

	typedef enum logic [2:0]
	{
		OP_WR = 3'h0,
		OP_SET = 3'h1,
		OP_CLR = 3'h2,
		OP_POLL = 3'h3,
		OP_SKIPZ = 3'h4,
		OP_CLKON = 3'h5,
		OP_CLKOFF = 3'h6
	} udsc_op_e;

	typedef struct packed
	{
		udsc_op_e kind;
		logic [7:0] addr;
		logic [31:0] val;
		logic [31:0] mask;
		logic last;
	} udsc_op_s;

endpackage : udsc_pkg

// ==== inc/udsc_if.sv ====
// Register port between the firmware end and the device end, plus the
// port clock enables that the firmware end controls.
`timescale 1ns/1ps
interface udsc_reg_if;
	logic [7:0] regAddr;
	logic regWr;
	logic regRd;
	logic [31:0] regWdata;
	logic [31:0] regRdata;
	logic irq;
	logic busClkOn;
	logic usbClkOn;

	modport dev
	(
		input regAddr, regWr, regRd, regWdata, busClkOn, usbClkOn,
		output regRdata, irq
	);
	modport fw
	(
		output regAddr, regWr, regRd, regWdata, busClkOn, usbClkOn,
		input regRdata, irq
	);
endinterface : udsc_reg_if

// ==== core/udsc_timer.sv ====
// Saturating elapsed-time counter; clears whenever run is low.
// Assumes run is a clean level in the clk domain.
`timescale 1ns/1ps
`include "udsc_cfg.svh"
module udsc_timer #(
	parameter int LIMIT = 20000
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic run,
	output logic expired
);
	import udsc_pkg::*;

	typedef struct packed
	{
		logic [19:0] count;
	} udsc_tmr_s;

	udsc_tmr_s s_ff;
	udsc_tmr_s nxt_s;

	always_comb
	begin
		nxt_s = s_ff;
		if (!run)
			nxt_s.count = 20'h0;
		else if (s_ff.count < LIMIT[19:0])
			nxt_s.count = s_ff.count + 20'h1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign expired = run && (s_ff.count >= LIMIT[19:0]);
endmodule : udsc_timer

// ==== core/udsc_firmware.sv ====
// Firmware end: runs the documented register procedures over the register
// port on command. Assumes the device answers a read on the next cycle.
`timescale 1ns/1ps
`include "udsc_cfg.svh"
module udsc_firmware
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register side
	udsc_reg_if.fw rif,
	// Commands
	input wire logic cmdValid,
	input wire udsc_pkg::udsc_cmd_e cmd,
	input wire logic cmdEp,
	input wire logic [6:0] cmdAddr,
	input wire logic [2:0] cmdKind,
	output logic cmdReady,
	output logic cmdDone
);
	import udsc_pkg::*;

	typedef struct packed
	{
		udsc_seq_e seq;
		udsc_cmd_e cmd;
		logic ep;
		logic [6:0] addr;
		logic [2:0] kind;
		logic [3:0] idx;
		logic [7:0] regAddr;
		logic regWr;
		logic regRd;
		logic [31:0] regWdata;
		logic busClk;
		logic usbClk;
		logic done;
	} udsc_fw_s;

	udsc_fw_s s_ff;
	udsc_fw_s nxt_s;
	udsc_op_s op;

	function automatic udsc_op_s mk(udsc_op_e k, logic [7:0] a, logic [31:0] m,
		logic [31:0] v, logic l);
		udsc_op_s o;
		o.kind = k;
		o.addr = a;
		o.mask = m;
		o.val = v;
		o.last = l;
		return o;
	endfunction : mk

	// Procedure table: one step per index for each command
	function automatic udsc_op_s stepOp(udsc_fw_s f);
		logic [7:0] csr;
		logic [31:0] tp;
		logic [31:0] tc;
		logic [31:0] dis;
		logic [31:0] send_resume_bit;
		csr = `UDSC_OFS_CSR + {5'h0, f.ep, 2'h0};
		tp = 32'h1 << `UDSC_CSR_TX_PACKET_READY;
		tc = 32'h1 << `UDSC_CSR_TX_COMPLETE_FLAG;
		dis = 32'h1 << `UDSC_TXVC_TRANSCEIVER_DISABLE_BIT;
		send_resume_bit = 32'h1 << `UDSC_GLB_ESR;
		stepOp = mk(OP_CLKON, 8'h0, 32'h0, 32'h0, 1'b1);
		case (f.cmd)
			CMD_CANCEL1:
				case (f.idx)
					4'h0: stepOp = mk(OP_SKIPZ, csr, tp, 32'h1, 1'b0); // RULE1
					4'h1: stepOp = mk(OP_CLR, csr, tp, 32'h0, 1'b0); // RULE1
					4'h2: stepOp = mk(OP_WR, `UDSC_OFS_RSTEP, 32'h0, 32'(1 << f.ep), 1'b0);
					default: stepOp = mk(OP_WR, `UDSC_OFS_RSTEP, 32'h0, 32'h0, 1'b1);
				endcase
			CMD_CANCEL2:
				case (f.idx)
					4'h0: stepOp = mk(OP_SKIPZ, csr, tp, 32'h5, 1'b0); // RULE2
					4'h1: stepOp = mk(OP_CLR, csr, tp, 32'h0, 1'b0); // RULE2
					4'h2: stepOp = mk(OP_POLL, csr, tp, 32'h0, 1'b0); // RULE2
					4'h3: stepOp = mk(OP_SET, csr, tp, 32'h0, 1'b0); // RULE2
					4'h4: stepOp = mk(OP_POLL, csr, tp, tp, 1'b0); // RULE2
					4'h5: stepOp = mk(OP_CLR, csr, tp, 32'h0, 1'b0); // RULE2
					4'h6: stepOp = mk(OP_WR, `UDSC_OFS_RSTEP, 32'h0, 32'(1 << f.ep), 1'b0);
					default: stepOp = mk(OP_WR, `UDSC_OFS_RSTEP, 32'h0, 32'h0, 1'b1);
				endcase
			CMD_DEFAULT:
				case (f.idx)
					4'h0: stepOp = mk(OP_SET, `UDSC_OFS_CSR, 32'h1 << `UDSC_CSR_EPEN, 32'h0,
						1'b0); // RULE9
					4'h1: stepOp = mk(OP_WR, `UDSC_OFS_IER, 32'h0, 32'h2301, 1'b0); // RULE9
					default: stepOp = mk(OP_CLR, `UDSC_OFS_TXVC, dis, 32'h0, 1'b1); // RULE9
				endcase
			CMD_SETADDR:
				case (f.idx)
					// Status stage is an empty IN packet; without ready it never completes
					4'h0: stepOp = mk(OP_SET, `UDSC_OFS_CSR, tp, 32'h0, 1'b0); // RULE10
					4'h1: stepOp = mk(OP_POLL, `UDSC_OFS_CSR, tc, tc, 1'b0); // RULE10
					4'h2: stepOp = mk(OP_CLR, `UDSC_OFS_CSR, tc, 32'h0, 1'b0); // RULE10
					4'h3: stepOp = mk(OP_POLL, `UDSC_OFS_CSR, tc, 32'h0, 1'b0); // RULE10
					4'h4: stepOp = mk(OP_SET, `UDSC_OFS_GLB, 32'h1, 32'h0, 1'b0); // RULE10
					default: stepOp = mk(OP_WR, `UDSC_OFS_FADDR, 32'h0,
						{24'h0, 1'b1, f.addr}, 1'b1); // RULE10
				endcase
			CMD_CONFIG:
				case (f.idx)
					4'h0: stepOp = mk(OP_WR, `UDSC_OFS_CSR + 8'h4, 32'h0,
						{16'h0, 1'b1, 4'h0, f.kind, 8'h0}, 1'b0); // RULE11
					4'h1: stepOp = mk(OP_SET, `UDSC_OFS_GLB, 32'h2, 32'h0, 1'b0);
					default: stepOp = mk(OP_WR, `UDSC_OFS_IER, 32'h0, 32'h2, 1'b1); // RULE11
				endcase
			CMD_SUSPEND:
				case (f.idx)
					4'h0: stepOp = mk(OP_WR, `UDSC_OFS_ICR, 32'h0, 32'h100, 1'b0); // RULE14
					4'h1: stepOp = mk(OP_SET, `UDSC_OFS_TXVC, dis, 32'h0, 1'b0); // RULE14
					default: stepOp = mk(OP_CLKOFF, 8'h0, 32'h0, 32'h0, 1'b1); // RULE14
				endcase
			CMD_RESUME:
				case (f.idx)
					4'h0: stepOp = mk(OP_CLKON, 8'h0, 32'h0, 32'h0, 1'b0); // RULE13
					4'h1: stepOp = mk(OP_WR, `UDSC_OFS_ICR, 32'h0, 32'h2200, 1'b0); // RULE13
					default: stepOp = mk(OP_CLR, `UDSC_OFS_TXVC, dis, 32'h0, 1'b1); // RULE13
				endcase
			CMD_RWAKE:
				case (f.idx)
					4'h0: stepOp = mk(OP_CLKON, 8'h0, 32'h0, 32'h0, 1'b0); // RULE16
					4'h1: stepOp = mk(OP_CLR, `UDSC_OFS_TXVC, dis, 32'h0, 1'b0); // RULE16
					4'h2: stepOp = mk(OP_SET, `UDSC_OFS_GLB, 32'h10, 32'h0, 1'b0); // RULE16
					4'h3: stepOp = mk(OP_CLR, `UDSC_OFS_GLB, send_resume_bit, 32'h0, 1'b0); // RULE16
					default: stepOp = mk(OP_SET, `UDSC_OFS_GLB, send_resume_bit, 32'h0, 1'b1); // RULE16
				endcase
			CMD_CONNECT:
				case (f.idx)
					4'h0: stepOp = mk(OP_CLKON, 8'h0, 32'h0, 32'h0, 1'b0); // RULE6
					default: stepOp = mk(OP_SET, `UDSC_OFS_TXVC, 32'h200, 32'h0, 1'b1);
				endcase
			CMD_PWRDOWN:
				case (f.idx)
					4'h0: stepOp = mk(OP_SET, `UDSC_OFS_TXVC, dis, 32'h0, 1'b0); // RULE18
					default: stepOp = mk(OP_CLKOFF, 8'h0, 32'h0, 32'h0, 1'b1); // RULE18
				endcase
			default: stepOp = mk(OP_CLKON, 8'h0, 32'h0, 32'h0, 1'b1);
		endcase
	endfunction : stepOp

	assign op = stepOp(s_ff);

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.regWr = 1'b0;
		nxt_s.regRd = 1'b0;
		nxt_s.done = 1'b0;
		case (s_ff.seq)
			SQ_IDLE:
				if (cmdValid)
				begin
					nxt_s.cmd = cmd;
					nxt_s.ep = cmdEp;
					nxt_s.addr = cmdAddr;
					nxt_s.kind = cmdKind;
					nxt_s.idx = 4'h0;
					nxt_s.seq = SQ_ISSUE;
				end
			SQ_ISSUE:
			begin
				nxt_s.regAddr = op.addr;
				nxt_s.regWdata = op.val;
				case (op.kind)
					OP_WR:
					begin
						nxt_s.regWr = 1'b1;
						nxt_s.seq = SQ_WRITE;
					end
					OP_CLKON, OP_CLKOFF:
					begin
						nxt_s.busClk = (op.kind == OP_CLKON);
						nxt_s.usbClk = (op.kind == OP_CLKON);
						nxt_s.idx = s_ff.idx + 4'h1;
						nxt_s.done = op.last;
						nxt_s.seq = op.last ? SQ_IDLE : SQ_ISSUE;
					end
					default:
					begin
						nxt_s.regRd = 1'b1;
						nxt_s.seq = SQ_READ;
					end
				endcase
			end
			SQ_READ: nxt_s.seq = SQ_EVAL;
			SQ_EVAL:
			begin
				nxt_s.seq = SQ_ISSUE;
				case (op.kind)
					OP_SET, OP_CLR:
					begin
						nxt_s.regWdata = (op.kind == OP_SET) ? (rif.regRdata | op.mask)
							: (rif.regRdata & ~op.mask);
						nxt_s.regWr = 1'b1;
						nxt_s.seq = SQ_WRITE;
					end
					OP_POLL:
						if ((rif.regRdata & op.mask) == op.val)
							nxt_s.idx = s_ff.idx + 4'h1;
					default:
						nxt_s.idx = ((rif.regRdata & op.mask) == 32'h0)
							? s_ff.idx + op.val[3:0] + 4'h1 : s_ff.idx + 4'h1;
				endcase
			end
			SQ_WRITE:
			begin
				nxt_s.idx = s_ff.idx + 4'h1;
				nxt_s.done = op.last;
				nxt_s.seq = op.last ? SQ_IDLE : SQ_ISSUE;
			end
			default: nxt_s.seq = SQ_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_ff <= '0;
			s_ff.seq <= SQ_IDLE;
			s_ff.busClk <= 1'b1;
			s_ff.usbClk <= 1'b1;
		end
		else
			s_ff <= nxt_s;
	end

	assign rif.regAddr = s_ff.regAddr;
	assign rif.regWr = s_ff.regWr;
	assign rif.regRd = s_ff.regRd;
	assign rif.regWdata = s_ff.regWdata;
	assign rif.busClkOn = s_ff.busClk;
	assign rif.usbClkOn = s_ff.usbClk;
	assign cmdReady = (s_ff.seq == SQ_IDLE);
	assign cmdDone = s_ff.done;
endmodule : udsc_firmware

// ==== tb/udsc_checker.sv ====
// Checker on the register port and bus pins of the device end.
// Assumes one clock and a synchronous active high reset; no bind.
`timescale 1ns/1ps
module udsc_checker #(
	parameter int WAKE_CYC = 60,
	parameter int KDRV_CYC = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic regWr,
	input wire logic [31:0] regWdata,
	input wire logic irq,
	input wire logic busClkOn,
	// Bus side
	input wire logic busIdle,
	input wire logic busResetSe0,
	input wire logic pullupOn,
	input wire logic kStateDrive,
	input wire logic suspended,
	input wire udsc_pkg::udsc_dstate_e devState
);
	import udsc_pkg::*;
	int kCnt;
	int sCnt;
	logic icrHit;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ------
	// Counters
	// ------
	// Counters, not repetitions, so the wake and K times may grow
	always_ff @(posedge clk)
	begin
		kCnt <= (rst || !kStateDrive) ? 0 : kCnt + 1;
		sCnt <= (rst || !suspended) ? 0 : sCnt + 1;
	end
	assign icrHit = regWr && busClkOn && regAddr == 8'h20 && regWdata[8];
	// ------
	// Properties
	// ------
	sequence s_endRst;
		##[1:3] (devState == ST_DEFAULT && irq);
	endsequence
	sequence s_kEnd;
		(kCnt == KDRV_CYC) ##[0:1] !suspended;
	endsequence
	property p_stable;
		!regWr && !$past(regWr) && !$past(regWr, 2) && !busResetSe0 && !$past(busResetSe0)
			&& !$past(busResetSe0, 2) |=> $stable(devState);
	endproperty
	a_stable: assert property (p_stable) else $error("state moved alone");
	property p_susp;
		$rose(suspended) |-> $past(icrHit) || $past(icrHit, 2);
	endproperty
	a_susp: assert property (p_susp) else $error("suspend without clear");
	property p_pup;
		regWr && busClkOn && regAddr == 8'h74 |-> ##2 pullupOn == $past(regWdata[9], 2);
	endproperty
	a_pup: assert property (p_pup) else $error("pull-up not as written");
	property p_endRst;
		$fell(busResetSe0) && pullupOn |-> s_endRst;
	endproperty
	a_endRst: assert property (p_endRst) else $error("no default after reset");
	property p_resume;
		suspended && !busIdle && !kStateDrive |-> ##[1:2] !suspended;
	endproperty
	a_resume: assert property (p_resume) else $error("resume missed");
	property p_kStart;
		$rose(kStateDrive) |-> suspended && sCnt >= WAKE_CYC - 1;
	endproperty
	a_kStart: assert property (p_kStart) else $error("K too early");
	property p_kEnd;
		$fell(kStateDrive) |-> s_kEnd;
	endproperty
	a_kEnd: assert property (p_kEnd) else $error("K end wrong");
	property p_kMax;
		kStateDrive |-> kCnt <= KDRV_CYC - 1;
	endproperty
	a_kMax: assert property (p_kMax) else $error("K too long");
endmodule : udsc_checker

// ==== tb/tb_top.sv ====
// Testbench: firmware end and device end joined over the register port.
// Assumes short timing parameters; bus conditions come from here.
`timescale 1ns/1ps
module tb_top;
	import udsc_pkg::*;
	localparam int IDLE = 20;
	localparam int WAKE = 60;
	localparam int KDRV = 16;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic busIdle = 1'h0;
	logic busResetSe0 = 1'h0;
	logic [1:0] inAck = 2'h0;
	logic ackOn = 1'h0;
	logic cmdValid = 1'h0;
	udsc_cmd_e cmd = CMD_CONNECT;
	logic cmdEp = 1'h0;
	logic [6:0] cmdAddr = 7'h0;
	logic [2:0] cmdKind = 3'h0;
	logic cmdReady, cmdDone, pullupOn, kStateDrive, transceiverOn, suspended;
	udsc_dstate_e devState;
	logic [6:0] q[$];
	int bad_count = 0;
	int num_checks = 0;
	int n;
	udsc_reg_if rif();
	udsc_device #(.IDLE_CYC(IDLE), .WAKE_CYC(WAKE), .KDRV_CYC(KDRV)) udsc_device_inst (
		.clk(clk), .rst(rst), .rif(rif), .busIdle(busIdle), .busResetSe0(busResetSe0),
		.inAck(inAck), .pullupOn(pullupOn), .kStateDrive(kStateDrive),
		.transceiverOn(transceiverOn), .suspended(suspended), .devState(devState));
	udsc_firmware udsc_firmware_inst (.clk(clk), .rst(rst), .rif(rif), .cmdValid(cmdValid),
		.cmd(cmd), .cmdEp(cmdEp), .cmdAddr(cmdAddr), .cmdKind(cmdKind),
		.cmdReady(cmdReady), .cmdDone(cmdDone));
	udsc_checker #(.WAKE_CYC(WAKE), .KDRV_CYC(KDRV)) udsc_checker_inst (.clk(clk), .rst(rst),
		.regAddr(rif.regAddr), .regWr(rif.regWr), .regWdata(rif.regWdata), .irq(rif.irq),
		.busClkOn(rif.busClkOn), .busIdle(busIdle), .busResetSe0(busResetSe0),
		.pullupOn(pullupOn), .kStateDrive(kStateDrive), .suspended(suspended),
		.devState(devState));
	// ------
	// Tasks
	// ------
	task automatic chk(string what, logic [6:0] exp, logic [6:0] got);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	// Expected {pull-up, transceiver, state} is noted before the command goes out
	task automatic run(udsc_cmd_e c, logic [6:0] exp);
		q.push_back(exp);
		@(negedge clk);
		cmd = c;
		cmdEp = 1'($urandom);
		cmdAddr = 7'($urandom);
		cmdKind = 3'($urandom);
		cmdValid = 1'h1;
		@(negedge clk);
		cmdValid = 1'h0;
		for (n = 0; n < 3000 && cmdDone !== 1'h1; n++)
			@(negedge clk);
		repeat (4) @(negedge clk);
	endtask : run
	task automatic bus_reset();
		busResetSe0 = 1'h1;
		repeat (10) @(negedge clk);
		busResetSe0 = 1'h0;
		repeat (4) @(negedge clk);
		chk("devState", {2'h0, ST_DEFAULT}, {2'h0, devState});
		chk("irq", 7'h1, {6'h0, rif.irq});
	endtask : bus_reset
	task automatic idle_wait();
		busIdle = 1'h1;
		repeat (IDLE + 6) @(negedge clk);
	endtask : idle_wait
	// ------
	// Processes
	// ------
	initial
	begin
		forever #25 clk = ~clk;
	end
	initial
	begin
		forever
		begin
			@(posedge clk iff cmdDone === 1'h1);
			repeat (2) @(negedge clk);
			chk("state", q.pop_front(), {pullupOn, transceiverOn, devState});
		end
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
	// Host side: random IN acknowledges while enabled
	initial
	begin
		forever
		begin
			@(negedge clk);
			inAck = ackOn ? 2'($urandom) : 2'h0;
		end
	end
	initial
	begin
		void'($urandom(32'h361a));
		repeat (8) @(negedge clk);
		rst = 1'h0;
		run(CMD_CONNECT, {2'h2, ST_POWERED});
		bus_reset();
		run(CMD_DEFAULT, {2'h3, ST_DEFAULT});
		$display("T1 end");
		// Host takes the status packet while the address procedure waits on it
		ackOn = 1'h1;
		run(CMD_SETADDR, {2'h3, ST_ADDRESS});
		ackOn = 1'h0;
		run(CMD_CONFIG, {2'h3, ST_CONFIG});
		$display("T2 end");
		idle_wait();
		run(CMD_SUSPEND, {2'h2, ST_CONFIG});
		chk("suspended", 7'h1, {6'h0, suspended});
		busIdle = 1'h0;
		repeat (3) @(negedge clk);
		chk("suspended", 7'h0, {6'h0, suspended});
		run(CMD_RESUME, {2'h3, ST_CONFIG});
		$display("T3 end");
		idle_wait();
		run(CMD_SUSPEND, {2'h2, ST_CONFIG});
		run(CMD_RWAKE, {2'h3, ST_CONFIG});
		for (n = 0; n < 300 && kStateDrive !== 1'h1; n++)
			@(negedge clk);
		for (n = 0; n < 300 && kStateDrive !== 1'h0; n++)
			@(negedge clk);
		chk("kLength", 7'(KDRV), 7'(n));
		chk("suspended", 7'h0, {6'h0, suspended});
		busIdle = 1'h0;
		$display("T4 end");
		bus_reset();
		run(CMD_DEFAULT, {2'h3, ST_DEFAULT});
		run(CMD_CANCEL1, {2'h3, ST_DEFAULT});
		run(CMD_CANCEL2, {2'h3, ST_DEFAULT});
		run(CMD_PWRDOWN, {2'h2, ST_DEFAULT});
		chk("queue", 7'h0, 7'(q.size()));
		$display("T5 end");
		give_verdict();
	end
endmodule : tb_top
